// file: rtl/llm_cfg.svh
// constants, register map and timing for the latching limit monitor
`ifndef LLM_CFG_SVH
`define LLM_CFG_SVH

`define LLM_CLK_HZ 40000000
`define LLM_TICK_S 1
`define LLM_HOLD_S 3
`define LLM_TIMER_MAX 16'd9999

`define LLM_REG_CTRL 4'h0
`define LLM_REG_SETPOINT 4'h1
`define LLM_REG_HYST 4'h2
`define LLM_REG_CEIL 4'h3
`define LLM_REG_FLOOR 4'h4
`define LLM_REG_PASS 4'h5
`define LLM_REG_ENTRY 4'h6
`define LLM_REG_STATUS 4'h7
`define LLM_REG_TIMER 4'h8
`define LLM_REG_PEAK 4'h9
`define LLM_REG_EVT 4'ha
`define LLM_REG_MASK 4'hb
`define LLM_REG_VALUE 4'hc

`define LLM_CTRL_DIR 0
`define LLM_CTRL_RESTART 1
`define LLM_CTRL_ACTION 2
`define LLM_CTRL_LOCK 3
`define LLM_CTRL_UNIT 4
`define LLM_CTRL_RESTORE 5
`define LLM_CTRL_PEAKSCR 6

`define LLM_EVT_EXCEED 0
`define LLM_EVT_RETURN 1
`define LLM_EVT_RELEASE 2
`define LLM_EVT_REJECT 3

`define LLM_RST_SETPOINT 16'h0000
`define LLM_RST_HYST 16'h0005
`define LLM_RST_HYST_MAX 16'h0064
`define LLM_RST_CEIL 16'h03e8
`define LLM_RST_FLOOR 16'h0000
`define LLM_RST_PASS 16'h0000
`define LLM_PASS_MAX 16'h270f

`endif

// file: rtl/llm_pkg.sv
// types shared by the latching limit monitor
package llm_pkg;
    typedef struct packed {
        logic dir_low;
        logic restart_on;
        logic direct;
        logic lock;
        logic unit_ms;
        logic peak_screen;
    } llm_ctrl_s;

    typedef struct packed {
        logic [15:0] setpoint;
        logic [15:0] hyst;
        logic [15:0] ceil;
        logic [15:0] floor;
        logic [15:0] pass;
    } llm_limits_s;

    typedef enum logic [1:0] {
        LLM_NORMAL,
        LLM_EXCEED,
        LLM_LATCHED
    } llm_state_e;
endpackage

// file: rtl/llm_monitor.sv
// latching limit monitor with Avalon-MM register slave
`timescale 1ns/100ps
`include "llm_cfg.svh"
module llm_monitor import llm_pkg::*; #(
    parameter int TICK_CYCLES = `LLM_CLK_HZ * `LLM_TICK_S,
    parameter int HOLD_TICKS = `LLM_HOLD_S
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic signed [15:0] PROCESS_VALUE,
    input wire logic RESET_KEY,
    output logic LIMIT_RELAY,
    output logic RELAY_NC_CLOSED,
    output logic RELAY_NO_CLOSED,
    output logic EXCEED_LAMP,
    output logic RELAY_STATE_LAMP,
    output logic IRQ
);
    // refuse settings the counters cannot hold
    if (TICK_CYCLES < 2 || HOLD_TICKS < 1 || HOLD_TICKS > 255) begin
        $error("llm_monitor: unsupported parameters");
    end

    function automatic logic beyond(input logic low, input logic signed [15:0] pv, input logic signed [15:0] sp);
        beyond = low ? (pv < sp) : (pv > sp);
    endfunction

    // ==========================================================
    // settings
    llm_ctrl_s ctrl;
    llm_limits_s lim;
    logic access_ok;
    logic [3:0] evt;
    logic [3:0] mask;
    logic bus_done;
    logic wr_ok;
    logic set_reject;
    logic [15:0] wdat;

    assign wdat = AVS_WRITEDATA[15:0];
    assign wr_ok = AVS_WRITE && !bus_done && AVS_BYTEENABLE[1:0] == 2'b11;

    always_ff @(posedge CLK_SYS) begin
        set_reject <= 1'b0;
        if (!RST_N) begin
            ctrl <= '0;
            lim <= {`LLM_RST_SETPOINT, `LLM_RST_HYST, `LLM_RST_CEIL, `LLM_RST_FLOOR, `LLM_RST_PASS};
        end else if (wr_ok && AVS_ADDRESS == `LLM_REG_CTRL && access_ok && !ctrl.lock && wdat[`LLM_CTRL_RESTORE]) begin
            ctrl <= '0;
            lim <= {`LLM_RST_SETPOINT, `LLM_RST_HYST, `LLM_RST_CEIL, `LLM_RST_FLOOR, lim.pass};
        end else if (wr_ok && access_ok) begin
            case (AVS_ADDRESS)
                `LLM_REG_CTRL: begin
                    if (!ctrl.lock || !wdat[`LLM_CTRL_LOCK]) begin
                        ctrl.lock <= wdat[`LLM_CTRL_LOCK];
                    end
                    ctrl.peak_screen <= wdat[`LLM_CTRL_PEAKSCR];
                    if (!ctrl.lock) begin
                        ctrl.dir_low <= wdat[`LLM_CTRL_DIR];
                        ctrl.restart_on <= wdat[`LLM_CTRL_RESTART];
                        ctrl.direct <= wdat[`LLM_CTRL_ACTION];
                        ctrl.unit_ms <= wdat[`LLM_CTRL_UNIT];
                    end
                end
                `LLM_REG_SETPOINT: begin
                    if (ctrl.lock || $signed(wdat) > $signed(lim.ceil) || $signed(wdat) < $signed(lim.floor)) begin
                        set_reject <= 1'b1;
                    end else begin
                        lim.setpoint <= wdat;
                    end
                end
                `LLM_REG_HYST: begin
                    if (!ctrl.lock && wdat <= `LLM_RST_HYST_MAX) begin
                        lim.hyst <= wdat;
                    end
                end
                `LLM_REG_CEIL: begin
                    if (!ctrl.lock) begin
                        lim.ceil <= wdat;
                    end
                end
                `LLM_REG_FLOOR: begin
                    if (!ctrl.lock) begin
                        lim.floor <= wdat;
                    end
                end
                `LLM_REG_PASS: begin
                    if (!ctrl.lock && wdat <= `LLM_PASS_MAX) begin
                        lim.pass <= wdat;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // passcode entry
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            access_ok <= 1'b0;
        end else if (wr_ok && AVS_ADDRESS == `LLM_REG_ENTRY) begin
            access_ok <= (wdat == lim.pass);
        end
    end

    // ==========================================================
    // one-second tick
    logic [31:0] tick_cnt;
    logic tick;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 32'h1;
        end
    end

    // ==========================================================
    // reset key hold
    logic [7:0] hold_cnt;
    logic key_fire;
    logic key_armed;
    always_ff @(posedge CLK_SYS) begin
        key_fire <= 1'b0;
        if (!RST_N) begin
            hold_cnt <= '0;
            key_armed <= 1'b1;
        end else if (!RESET_KEY) begin
            hold_cnt <= '0;
            key_armed <= 1'b1;
        end else if (tick && key_armed) begin
            // first tick may come early, so one extra tick guarantees the full hold
            if (hold_cnt == 8'(HOLD_TICKS)) begin
                key_fire <= 1'b1;
                key_armed <= 1'b0;
            end else begin
                hold_cnt <= hold_cnt + 8'h1;
            end
        end
    end

    // ==========================================================
    // limit state machine
    llm_state_e state;
    logic over;
    logic inside_hyst;
    logic signed [16:0] clear_lvl;
    logic started;
    assign over = beyond(ctrl.dir_low, PROCESS_VALUE, $signed(lim.setpoint));
    assign clear_lvl = ctrl.dir_low ? $signed(lim.setpoint) + $signed({1'b0, lim.hyst})
                                    : $signed(lim.setpoint) - $signed({1'b0, lim.hyst});
    assign inside_hyst = ctrl.dir_low ? (PROCESS_VALUE >= clear_lvl) : (PROCESS_VALUE <= clear_lvl);

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state <= LLM_NORMAL;
            started <= 1'b0;
        end else if (!started) begin
            started <= 1'b1;
            state <= (ctrl.restart_on && !over) ? LLM_NORMAL : LLM_LATCHED;
        end else begin
            case (state)
                LLM_NORMAL: if (over) state <= LLM_EXCEED;
                LLM_EXCEED: if (inside_hyst) state <= LLM_LATCHED;
                LLM_LATCHED: begin
                    if (over) begin
                        state <= LLM_EXCEED;
                    end else if (key_fire && inside_hyst) begin
                        state <= LLM_NORMAL;
                    end
                end
                default: state <= LLM_NORMAL;
            endcase
        end
    end

    // ==========================================================
    // over-limit timer
    logic [15:0] timer;
    logic [5:0] sub_cnt;
    logic was_over;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            timer <= '0;
            sub_cnt <= '0;
            was_over <= 1'b0;
        end else begin
            was_over <= (state == LLM_EXCEED);
            if (state == LLM_EXCEED && !was_over) begin
                timer <= '0;
                sub_cnt <= '0;
            end else if (state != LLM_EXCEED && key_fire) begin
                timer <= '0;
                sub_cnt <= '0;
            end else if (state == LLM_EXCEED && tick && timer != `LLM_TIMER_MAX) begin
                // one count per tick in mm.ss, per 36 ticks in hh.mm
                if (sub_cnt == (ctrl.unit_ms ? 6'd0 : 6'd35)) begin
                    sub_cnt <= '0;
                    timer <= timer + 16'h1;
                end else begin
                    sub_cnt <= sub_cnt + 6'h1;
                end
            end
        end
    end

    // ==========================================================
    // peak tracking
    logic signed [15:0] peak;
    logic peak_valid;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || (ctrl.peak_screen && key_fire)) begin
            peak_valid <= 1'b0;
            peak <= '0;
        end else if (!peak_valid || beyond(ctrl.dir_low, PROCESS_VALUE, peak)) begin
            peak_valid <= 1'b1;
            peak <= PROCESS_VALUE;
        end
    end

    // ==========================================================
    // relay and lamps
    logic status_on;
    assign status_on = (state != LLM_NORMAL);
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            LIMIT_RELAY <= 1'b0;
            RELAY_NC_CLOSED <= 1'b1;
            RELAY_NO_CLOSED <= 1'b0;
            EXCEED_LAMP <= 1'b0;
            RELAY_STATE_LAMP <= 1'b0;
        end else begin
            LIMIT_RELAY <= ctrl.direct ? status_on : !status_on;
            RELAY_STATE_LAMP <= ctrl.direct ? !status_on : status_on;
            RELAY_NC_CLOSED <= !status_on;
            RELAY_NO_CLOSED <= status_on;
            EXCEED_LAMP <= (state == LLM_EXCEED);
        end
    end

    // ==========================================================
    // events and interrupt
    logic [3:0] evt_set;
    assign evt_set = {set_reject, key_fire && state == LLM_LATCHED && inside_hyst && !over,
                      state == LLM_EXCEED && inside_hyst, state != LLM_EXCEED && over && started};
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            evt <= '0;
            mask <= '0;
            IRQ <= 1'b0;
        end else begin
            if (wr_ok && AVS_ADDRESS == `LLM_REG_EVT) begin
                evt <= (evt & ~wdat[3:0]) | evt_set;
            end else begin
                evt <= evt | evt_set;
            end
            if (wr_ok && AVS_ADDRESS == `LLM_REG_MASK) begin
                mask <= wdat[3:0];
            end
            IRQ <= |(evt & mask);
        end
    end

    // ==========================================================
    // bus slave: one wait cycle per access
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            bus_done <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= '0;
        end else if ((AVS_READ || AVS_WRITE) && !bus_done) begin
            bus_done <= 1'b1;
            AVS_WAITREQUEST <= 1'b0;
            case (AVS_ADDRESS)
                `LLM_REG_CTRL: AVS_READDATA <= {25'h0, ctrl.peak_screen, 1'b0, ctrl.unit_ms,
                                               ctrl.lock, ctrl.direct, ctrl.restart_on, ctrl.dir_low};
                `LLM_REG_SETPOINT: AVS_READDATA <= {16'h0, lim.setpoint};
                `LLM_REG_HYST: AVS_READDATA <= {16'h0, lim.hyst};
                `LLM_REG_CEIL: AVS_READDATA <= {16'h0, lim.ceil};
                `LLM_REG_FLOOR: AVS_READDATA <= {16'h0, lim.floor};
                `LLM_REG_ENTRY: AVS_READDATA <= {31'h0, access_ok};
                `LLM_REG_STATUS: AVS_READDATA <= {28'h0, state == LLM_LATCHED, over,
                                                  state == LLM_EXCEED, status_on};
                `LLM_REG_TIMER: AVS_READDATA <= {16'h0, timer};
                `LLM_REG_PEAK: AVS_READDATA <= {16'h0, peak};
                `LLM_REG_EVT: AVS_READDATA <= {28'h0, evt};
                `LLM_REG_MASK: AVS_READDATA <= {28'h0, mask};
                `LLM_REG_VALUE: AVS_READDATA <= {16'h0, PROCESS_VALUE};
                default: AVS_READDATA <= '0;
            endcase
        end else begin
            bus_done <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
        end
    end
endmodule

// file: verification/llm_monitor_props.sv
// pin assertions for the limit monitor
`timescale 1ns/100ps
module llm_monitor_chk (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic RESET_KEY,
    input wire logic LIMIT_RELAY,
    input wire logic RELAY_NC_CLOSED,
    input wire logic RELAY_NO_CLOSED,
    input wire logic EXCEED_LAMP,
    input wire logic RELAY_STATE_LAMP,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    // ==========
    // bus and relay relations
    sequence s_req;
        $rose(AVS_READ || AVS_WRITE);
    endsequence
    sequence s_ack;
        ##[1:2] !AVS_WAITREQUEST;
    endsequence
    a_answer_bound: assert property (s_req |-> s_ack) else $error("no bus answer");
    a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long ack");
    a_no_spurious: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("ack without request");
    a_contacts_apart: assert property (RELAY_NC_CLOSED != RELAY_NO_CLOSED) else $error("contacts");
    a_relay_lamp: assert property ($past(RST_N, 4) |-> LIMIT_RELAY != RELAY_STATE_LAMP)
        else $error("relay and lamp");
    a_exceed_latch: assert property ($rose(EXCEED_LAMP) |-> ##[0:2] RELAY_NO_CLOSED)
        else $error("no latch");
    a_return_held: assert property ($fell(EXCEED_LAMP) |-> RELAY_NO_CLOSED [*3])
        else $error("latch lost");
    a_release_key: assert property ($rose(RELAY_NC_CLOSED) |-> $past(RESET_KEY, 3))
        else $error("release without key");
    a_irq_drop: assert property ($fell(IRQ) |-> $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3))
        else $error("irq dropped alone");
endmodule
bind llm_monitor llm_monitor_chk i_llm_monitor_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .RESET_KEY(RESET_KEY), .LIMIT_RELAY(LIMIT_RELAY),
    .RELAY_NC_CLOSED(RELAY_NC_CLOSED), .RELAY_NO_CLOSED(RELAY_NO_CLOSED), .EXCEED_LAMP(EXCEED_LAMP),
    .RELAY_STATE_LAMP(RELAY_STATE_LAMP), .IRQ(IRQ));

// file: verification/llm_field.sv
// process value source and operator key
`timescale 1ns/100ps
module llm_field import llm_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic signed [15:0] pv_cmd,
    input wire logic press,
    output logic signed [15:0] process_value,
    output logic reset_key
);
    logic [7:0] held;
    // ==========
    // value follows command; key held well past the hold time
    always_ff @(posedge clk) begin
        process_value <= pv_cmd;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reset_key <= 1'b0;
            held <= 8'h00;
        end else if (press && !reset_key) begin
            reset_key <= 1'b1;
            held <= 8'h3c;
        end else if (held != 8'h00) begin
            held <= held - 8'h01;
        end else begin
            reset_key <= 1'b0;
        end
    end
endmodule

// file: verification/llm_monitor_bench.sv
// self-checking bench for the limit monitor
`timescale 1ns/100ps
`include "llm_cfg.svh"
module llm_monitor_bench import llm_pkg::*; ;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [3:0] be = 4'hf;
    logic [31:0] rdat, q, t1;
    logic wreq, relay, nc, no, exc, lamp, irq, press = 1'b0, key;
    logic signed [15:0] pv_cmd = 16'h0000;
    logic signed [15:0] pv;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    llm_monitor #(.TICK_CYCLES(10), .HOLD_TICKS(3)) i_llm_monitor (.CLK_SYS(clk_sys), .RST_N(rst_n),
        .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .PROCESS_VALUE(pv), .RESET_KEY(key), .LIMIT_RELAY(relay),
        .RELAY_NC_CLOSED(nc), .RELAY_NO_CLOSED(no), .EXCEED_LAMP(exc), .RELAY_STATE_LAMP(lamp), .IRQ(irq));
    llm_field i_llm_field (.clk(clk_sys), .rst_n(rst_n), .pv_cmd(pv_cmd), .press(press),
        .process_value(pv), .reset_key(key));
    always #12.5 clk_sys = ~clk_sys;
    // ==========
    // shared tasks
    task automatic bad(input string m);
        $display("BAD %0t %s", $time, m);
        miscompares++;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) bad(m);
    endtask
    task automatic chk_pin(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) bad(m);
    endtask
    task automatic pins(input logic r, input logic c, input logic o, input logic l, input string m);
        chk_pin(relay, r, m);
        chk_pin(nc, c, m);
        chk_pin(no, o, m);
        chk_pin(lamp, l, m);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        adr <= a;
        wdat <= {16'h0000, d};
        wr_en <= w;
        rd_en <= ~w;
        @(posedge clk_sys);
        while (wreq !== 1'b0) @(posedge clk_sys);
        q = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 16'h0000);
    endtask
    task automatic push_key;
        press <= 1'b1;
        @(posedge clk_sys);
        press <= 1'b0;
        @(posedge clk_sys);
        while (key === 1'b1) @(posedge clk_sys);
        cyc(4);
    endtask
    task automatic set_pv(input logic [15:0] v);
        pv_cmd <= v;
        cyc(6);
    endtask
    // ==========
    // scenarios
    task automatic t_reset;
        pins(1'b0, 1'b0, 1'b1, 1'b1, "power-on latch");
        chk_pin(exc, 1'b0, "equal is inside");
        rd(`LLM_REG_HYST);
        chk_word(q, 32'h00000005, "hyst default");
        rd(`LLM_REG_CEIL);
        chk_word(q, 32'h000003e8, "ceiling default");
        rd(`LLM_REG_CTRL);
        chk_word(q, 32'h00000000, "ctrl default");
        rd(4'hd);
        chk_word(q, 32'h00000000, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_access;
        wr(`LLM_REG_SETPOINT, 16'h0064);
        rd(`LLM_REG_SETPOINT);
        chk_word(q, 32'h00000000, "no passcode");
        wr(`LLM_REG_ENTRY, 16'h0000);
        rd(`LLM_REG_ENTRY);
        chk_pin(q[0], 1'b1, "access");
        wr(`LLM_REG_SETPOINT, 16'h0064);
        wr(`LLM_REG_MASK, 16'h0008);
        wr(`LLM_REG_SETPOINT, 16'h07d0);
        wr(`LLM_REG_FLOOR, 16'h000a);
        wr(`LLM_REG_SETPOINT, 16'h0005);
        rd(`LLM_REG_SETPOINT);
        chk_word(q, 32'h00000064, "bounds");
        cyc(3);
        chk_pin(irq, 1'b1, "reject irq");
        wr(`LLM_REG_EVT, 16'h0008);
        cyc(3);
        chk_pin(irq, 1'b0, "irq clear");
        $display("test access done");
    endtask
    task automatic t_timer;
        set_pv(16'h0032);
        push_key;
        pins(1'b1, 1'b1, 1'b0, 1'b0, "released");
        set_pv(16'h0096);
        chk_pin(exc, 1'b1, "exceed");
        pins(1'b0, 1'b0, 1'b1, 1'b1, "tripped");
        rd(`LLM_REG_STATUS);
        chk_word(q, 32'h00000007, "status tripped");
        rd(`LLM_REG_VALUE);
        chk_word(q, 32'h00000096, "value");
        rd(`LLM_REG_PEAK);
        chk_word(q, 32'h00000096, "peak");
        cyc(400);
        rd(`LLM_REG_TIMER);
        chk_pin(q <= 32'h3, 1'b1, "hh.mm rate");
        set_pv(16'h0061);
        chk_pin(exc, 1'b1, "inside hyst band");
        set_pv(16'h005e);
        chk_pin(exc, 1'b0, "returned");
        chk_pin(no, 1'b1, "still latched");
        wr(`LLM_REG_CTRL, 16'h0010);
        set_pv(16'h0096);
        cyc(194);
        rd(`LLM_REG_TIMER);
        t1 = q;
        chk_pin(t1 >= 32'h11 && t1 <= 32'h16, 1'b1, "mm.ss rate");
        push_key;
        rd(`LLM_REG_TIMER);
        chk_pin(q > t1, 1'b1, "reset ignored over");
        chk_pin(no, 1'b1, "no release over");
        set_pv(16'h005e);
        rd(`LLM_REG_TIMER);
        t1 = q;
        cyc(100);
        rd(`LLM_REG_TIMER);
        chk_word(q, t1, "timer stopped");
        set_pv(16'h0096);
        cyc(44);
        rd(`LLM_REG_TIMER);
        chk_pin(q <= 32'h7, 1'b1, "timer restart");
        set_pv(16'h005e);
        push_key;
        rd(`LLM_REG_TIMER);
        chk_word(q, 32'h00000000, "timer cleared");
        pins(1'b1, 1'b1, 1'b0, 1'b0, "released again");
        rd(`LLM_REG_EVT);
        chk_word(q, 32'h00000007, "events");
        wr(`LLM_REG_CTRL, 16'h0050);
        push_key;
        rd(`LLM_REG_PEAK);
        chk_word(q, 32'h0000005e, "peak cleared");
        $display("test timer done");
    endtask
    task automatic t_low;
        wr(`LLM_REG_CTRL, 16'h0001);
        cyc(6);
        chk_pin(exc, 1'b1, "low exceed");
        wr(`LLM_REG_CTRL, 16'h0005);
        cyc(4);
        pins(1'b1, 1'b0, 1'b1, 1'b0, "direct tripped");
        set_pv(16'h006e);
        chk_pin(exc, 1'b0, "low return");
        push_key;
        pins(1'b0, 1'b1, 1'b0, 1'b1, "direct released");
        wr(`LLM_REG_CTRL, 16'h000d);
        wr(`LLM_REG_SETPOINT, 16'h00c8);
        rd(`LLM_REG_SETPOINT);
        chk_word(q, 32'h00000064, "locked");
        wr(`LLM_REG_CTRL, 16'h0005);
        rd(`LLM_REG_CTRL);
        chk_word(q, 32'h00000005, "unlock");
        $display("test low and lock done");
    endtask
    task automatic t_restore;
        wr(`LLM_REG_HYST, 16'h000a);
        be <= 4'h0;
        wr(`LLM_REG_HYST, 16'h0007);
        be <= 4'hf;
        rd(`LLM_REG_HYST);
        chk_word(q, 32'h0000000a, "byte enables off");
        wr(`LLM_REG_CTRL, 16'h0020);
        rd(`LLM_REG_CTRL);
        chk_word(q, 32'h00000000, "restore clears");
        rd(`LLM_REG_HYST);
        chk_word(q, 32'h00000005, "hyst restored");
        $display("test restore done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad("timeout");
            end_sim;
        end
    end
    initial begin
        cyc(12);
        rst_n <= 1'b1;
        cyc(4);
        t_reset;
        t_access;
        t_timer;
        t_low;
        t_restore;
        end_sim;
    end
endmodule
